/* File: pkg/ad_pin_mux_defs.svh */
// Contract
// - system control bit 20 set with parallel port off turns pins into flags
// - flag mode maps pins 0-7 to flags 8-15, pins 8-15 to flags 0-7
// - boot straps: 00 spi slave, 01 spi master, 10 eprom, 11 internal rom
// - 8-bit mode, latch strobe high: A15:8 on pins 7:0, A23:16 on 15:8
// - 8-bit mode, latch strobe low: D7:0 on pins 7:0, A7:0 on 15:8
// - 16-bit mode: A15:0 on pins with latch strobe, then D15:0 after
// - read, write and latch strobe outputs are always driven, never floated
`ifndef AD_PIN_MUX_DEFS_SVH
`define AD_PIN_MUX_DEFS_SVH

`define REG_SYSTEM_CONTROL_REG        8'h00
`define REG_PP_ADDR       8'h01
`define REG_PP_DATA       8'h02
`define REG_PP_CTRL       8'h03
`define REG_FLAG_OUT      8'h04
`define REG_FLAG_DIR      8'h05
`define REG_FLAG_IN       8'h06
`define REG_BOOT          8'h07

`define SYSTEM_CONTROL_REG_PP_EN_BIT  0
`define SYSTEM_CONTROL_REG_WIDE_BIT   1
`define SYSTEM_CONTROL_REG_FLAG_BIT   20
`define SYSTEM_CONTROL_REG_RST        32'h0000_0000
`define SYSTEM_CONTROL_REG_MASK       32'h0010_0003

`define CTRL_START_BIT    0
`define CTRL_WRITE_BIT    1
`define STAT_BUSY_BIT     0
`define BOOT_VALID_BIT    2

`define BOOT_CODE_SPI_SLV 2'h0
`define BOOT_CODE_SPI_MST 2'h1
`define BOOT_CODE_EPROM   2'h2
`define BOOT_CODE_ROM     2'h3

`define CLK_PERIOD_NS     10
`define ALE_TIME_NS       20
`define STB_TIME_NS       40
`define REC_TIME_NS       10
`define NS_TO_CYC(t)      (((t) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ALE_CYC           4'(`NS_TO_CYC(`ALE_TIME_NS))
`define STB_CYC           4'(`NS_TO_CYC(`STB_TIME_NS))
`define REC_CYC           4'(`NS_TO_CYC(`REC_TIME_NS))
`define STRAP_SETTLE      2'h2

`endif

/* File: pkg/ad_pin_mux_pkg.sv */
package ad_pin_mux_pkg;

   typedef enum logic [1:0] {PP_IDLE, PP_ADDR, PP_STROBE, PP_RECOVER} pp_state_t;

   typedef enum logic [1:0] {BOOT_SPI_SLAVE, BOOT_SPI_MASTER, BOOT_PAR_EPROM,
                             BOOT_INT_ROM} boot_mode_t;

   typedef struct packed {
      logic [1:0] meta;
      logic [1:0] sync;
      logic [1:0] settle;
      logic       valid;
      boot_mode_t mode;
   } boot_state_t;

   typedef struct packed {
      pp_state_t   st;
      logic [3:0]  cnt;
      logic        dir;
      logic [31:0] system_control_reg;
      logic [23:0] addr;
      logic [15:0] wdat;
      logic [15:0] rdat;
      logic [15:0] flag_out;
      logic [15:0] flag_dir;
      logic [15:0] ad_meta;
      logic [15:0] ad_sync;
      logic [15:0] pin_out;
      logic [15:0] pin_oe;
      logic        ale;
      logic        rd_n;
      logic        wr_n;
      logic [31:0] rdata;
   } port_state_t;

endpackage

/* File: verilog/boot_strap_decode.sv */
`timescale 1ns/1ns
`include "ad_pin_mux_defs.svh"

module boot_strap_decode
(
   input  wire  logic                     clk_sys,
   input  wire  logic                     rst_b,
   input  wire  logic [1:0]               boot_select_straps,
   output ad_pin_mux_pkg::boot_mode_t     boot_mode,
   output logic                           boot_valid
);
   import ad_pin_mux_pkg::*;

   boot_state_t q;
   boot_state_t d;

   function automatic boot_mode_t decode_strap(input logic [1:0] code);
      boot_mode_t m;
      m = BOOT_INT_ROM;
      unique case (code)
         `BOOT_CODE_SPI_SLV: m = BOOT_SPI_SLAVE;
         `BOOT_CODE_SPI_MST: m = BOOT_SPI_MASTER;
         `BOOT_CODE_EPROM:   m = BOOT_PAR_EPROM;
         `BOOT_CODE_ROM:     m = BOOT_INT_ROM;
      endcase
      return m;
   endfunction

   // straps are caught once after release; later changes on the pins are ignored
   always_comb
   begin
      d = q;
      d.meta = boot_select_straps;
      d.sync = q.meta;
      if (!q.valid)
      begin
         if (q.settle == `STRAP_SETTLE)
         begin
            d.valid = 1'b1;
            d.mode  = decode_strap(q.sync);
         end
         else
         begin
            d.settle = q.settle + 2'h1;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         q <= '0;
      end
      else
      begin
         q <= d;
      end
   end

   assign boot_mode  = q.mode;
   assign boot_valid = q.valid;

endmodule

/* File: verilog/ad_pin_mux_parallel_port.sv */
`timescale 1ns/1ns
`include "ad_pin_mux_defs.svh"

module ad_pin_mux_parallel_port
(
   input  wire  logic                     clk_sys,
   input  wire  logic                     rst_b,
   input  wire  logic [7:0]               reg_addr,
   input  wire  logic [31:0]              reg_wdata,
   input  wire  logic                     reg_wr,
   input  wire  logic                     reg_rd,
   output logic [31:0]                    reg_rdata,
   input  wire  logic [15:0]              muxed_addr_data_pins_in,
   output logic [15:0]                    muxed_addr_data_pins_out,
   output logic [15:0]                    muxed_addr_data_pins_oe,
   output logic                           ale,
   output logic                           rd_n,
   output logic                           wr_n,
   input  wire  logic [1:0]               boot_select_straps,
   output ad_pin_mux_pkg::boot_mode_t     boot_mode,
   output logic                           flag_mode,
   output logic                           pp_busy
);
   import ad_pin_mux_pkg::*;

   port_state_t q;
   port_state_t d;
   boot_mode_t  boot_mode_w;
   logic        boot_valid_w;
   logic        pp_en;
   logic        wide;
   logic        fmode;
   logic        start;

   // pin i and pin i+8 trade halves; the mapping is its own inverse
   function automatic logic [15:0] pin_to_flag(input logic [15:0] v);
      return {v[7:0], v[15:8]};
   endfunction

   function automatic logic [15:0] addr_phase(input logic [23:0] a, input logic w);
      logic [15:0] p;
      if (w)
      begin
         p = a[15:0];
      end
      else
      begin
         p = {a[23:16], a[15:8]};
      end
      return p;
   endfunction

   function automatic logic [15:0] data_phase(input logic [23:0] a,
                                              input logic [15:0] dat,
                                              input logic        w);
      logic [15:0] p;
      if (w)
      begin
         p = dat;
      end
      else
      begin
         p = {a[7:0], dat[7:0]};
      end
      return p;
   endfunction

   function automatic logic [31:0] read_reg(input port_state_t s,
                                            input logic [7:0]  a,
                                            input boot_mode_t  bm,
                                            input logic        bv);
      logic [31:0] r;
      r = 32'h0000_0000;
      unique case (a)
         `REG_SYSTEM_CONTROL_REG:   r = s.system_control_reg;
         `REG_PP_ADDR:  r = {8'h00, s.addr};
         `REG_PP_DATA:  r = {16'h0000, s.rdat};
         `REG_PP_CTRL:  r = {31'h0000_0000, s.st != PP_IDLE};
         `REG_FLAG_OUT: r = {16'h0000, s.flag_out};
         `REG_FLAG_DIR: r = {16'h0000, s.flag_dir};
         `REG_FLAG_IN:  r = {16'h0000, pin_to_flag(s.ad_sync)};
         `REG_BOOT:     r = {29'h0000_0000, bv, 2'(bm)};
         default:       r = 32'h0000_0000;
      endcase
      return r;
   endfunction

   boot_strap_decode u_boot
   (
      .clk_sys            (clk_sys),
      .rst_b              (rst_b),
      .boot_select_straps (boot_select_straps),
      .boot_mode          (boot_mode_w),
      .boot_valid         (boot_valid_w)
   );

   always_comb
   begin
      d = q;
      pp_en = q.system_control_reg[`SYSTEM_CONTROL_REG_PP_EN_BIT];
      wide  = q.system_control_reg[`SYSTEM_CONTROL_REG_WIDE_BIT];
      // flags only once the port is off, so a live access never gets its pins stolen
      fmode = q.system_control_reg[`SYSTEM_CONTROL_REG_FLAG_BIT] && !pp_en;
      start = 1'b0;

      d.ad_meta = muxed_addr_data_pins_in;
      d.ad_sync = q.ad_meta;
      d.rdata   = 32'h0000_0000;

      if (reg_rd)
      begin
         d.rdata = read_reg(q, reg_addr, boot_mode_w, boot_valid_w);
      end

      if (reg_wr)
      begin
         unique case (reg_addr)
            `REG_SYSTEM_CONTROL_REG:
            begin
               d.system_control_reg = reg_wdata & `SYSTEM_CONTROL_REG_MASK;
            end
            `REG_PP_ADDR:
            begin
               if (q.st == PP_IDLE)
               begin
                  d.addr = reg_wdata[23:0];
               end
            end
            `REG_PP_DATA:
            begin
               if (q.st == PP_IDLE)
               begin
                  d.wdat = reg_wdata[15:0];
               end
            end
            `REG_PP_CTRL:
            begin
               start = reg_wdata[`CTRL_START_BIT] && (q.st == PP_IDLE) && pp_en && !fmode;
            end
            `REG_FLAG_OUT:
            begin
               d.flag_out = reg_wdata[15:0];
            end
            `REG_FLAG_DIR:
            begin
               d.flag_dir = reg_wdata[15:0];
            end
            default:
            begin
               d.cnt = q.cnt;
            end
         endcase
      end

      unique case (q.st)
         PP_IDLE:
         begin
            if (start)
            begin
               d.st  = PP_ADDR;
               d.cnt = `ALE_CYC - 4'h1;
               d.dir = reg_wdata[`CTRL_WRITE_BIT];
            end
         end
         PP_ADDR:
         begin
            if (q.cnt == 4'h0)
            begin
               d.st  = PP_STROBE;
               d.cnt = `STB_CYC - 4'h1;
            end
            else
            begin
               d.cnt = q.cnt - 4'h1;
            end
         end
         PP_STROBE:
         begin
            if (q.cnt == 4'h0)
            begin
               // sampled through the pin synchroniser, so pins must settle two cycles early
               if (!q.dir)
               begin
                  d.rdat = wide ? q.ad_sync : {8'h00, q.ad_sync[7:0]};
               end
               d.st  = PP_RECOVER;
               d.cnt = `REC_CYC - 4'h1;
            end
            else
            begin
               d.cnt = q.cnt - 4'h1;
            end
         end
         PP_RECOVER:
         begin
            if (q.cnt == 4'h0)
            begin
               d.st = PP_IDLE;
            end
            else
            begin
               d.cnt = q.cnt - 4'h1;
            end
         end
      endcase

      // turning the port off aborts an access in flight
      if (!d.system_control_reg[`SYSTEM_CONTROL_REG_PP_EN_BIT])
      begin
         d.st  = PP_IDLE;
         d.cnt = 4'h0;
      end

      // strobes are always driven; idle level is high for rd/wr, low for ale
      d.ale  = (d.st == PP_ADDR);
      d.rd_n = !((d.st == PP_STROBE) && !d.dir);
      d.wr_n = !((d.st == PP_STROBE) && d.dir);

      d.pin_out = 16'h0000;
      d.pin_oe  = 16'h0000;
      if (d.system_control_reg[`SYSTEM_CONTROL_REG_FLAG_BIT] && !d.system_control_reg[`SYSTEM_CONTROL_REG_PP_EN_BIT])
      begin
         d.pin_out = pin_to_flag(d.flag_out);
         d.pin_oe  = pin_to_flag(d.flag_dir);
      end
      else if (d.st == PP_ADDR)
      begin
         d.pin_out = addr_phase(d.addr, d.system_control_reg[`SYSTEM_CONTROL_REG_WIDE_BIT]);
         d.pin_oe  = 16'hffff;
      end
      else if (d.st == PP_STROBE || d.st == PP_RECOVER)
      begin
         d.pin_out = data_phase(d.addr, d.wdat, d.system_control_reg[`SYSTEM_CONTROL_REG_WIDE_BIT]);
         if (d.system_control_reg[`SYSTEM_CONTROL_REG_WIDE_BIT])
         begin
            d.pin_oe = d.dir ? 16'hffff : 16'h0000;
         end
         else
         begin
            d.pin_oe = {8'hff, d.dir ? 8'hff : 8'h00};
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         q        <= '0;
         q.system_control_reg <= `SYSTEM_CONTROL_REG_RST;
         q.rd_n   <= 1'b1;
         q.wr_n   <= 1'b1;
      end
      else
      begin
         q <= d;
      end
   end

   assign reg_rdata                = q.rdata;
   assign muxed_addr_data_pins_out = q.pin_out;
   assign muxed_addr_data_pins_oe  = q.pin_oe;
   assign ale                      = q.ale;
   assign rd_n                     = q.rd_n;
   assign wr_n                     = q.wr_n;
   assign boot_mode                = boot_mode_w;
   assign flag_mode                = q.system_control_reg[`SYSTEM_CONTROL_REG_FLAG_BIT] && !q.system_control_reg[`SYSTEM_CONTROL_REG_PP_EN_BIT];
   assign pp_busy                  = (q.st != PP_IDLE);

endmodule

/* File: verif/ad_pin_mux_checker.sv */
`timescale 1ns/1ns
module ad_pin_mux_checker
(
   input wire logic                 clk_sys,
   input wire logic                 rst_b,
   input wire logic                 reg_rd,
   input wire logic [31:0]          reg_rdata,
   input wire logic [15:0]          muxed_addr_data_pins_oe,
   input wire logic                 ale,
   input wire logic                 rd_n,
   input wire logic                 wr_n,
   input ad_pin_mux_pkg::boot_mode_t boot_mode,
   input wire logic                 flag_mode,
   input wire logic                 pp_busy
);
   import ad_pin_mux_pkg::*;
   // cycles since reset release, saturating; straps settle well before 7
   logic [2:0] age_q;
   logic [2:0] age_d;
   assign age_d = (age_q == 3'h7) ? age_q : age_q + 3'h1;
   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
         age_q <= 3'h0;
      else
         age_q <= age_d;
   end
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_b);
   AST_STROBE_EXCL: assert property ((rd_n || wr_n) && !(ale && !(rd_n && wr_n)))
      else $error("strobes overlap");
   AST_ALE_WIDTH: assert property ($rose(ale) |=> ale ##1 !ale)
      else $error("latch strobe width wrong");
   // an access aborted by port disable drops ale with no strobe and busy already low
   AST_STROBE_LEN: assert property ($fell(ale) && pp_busy |-> (!rd_n || !wr_n)[*4] ##1 (rd_n && wr_n))
      else $error("data strobe length wrong");
   AST_ADDR_DRIVEN: assert property (ale |-> muxed_addr_data_pins_oe == 16'hffff)
      else $error("address phase not driven");
   AST_WR_DRIVEN: assert property (!wr_n |-> muxed_addr_data_pins_oe == 16'hffff)
      else $error("write data phase not driven");
   AST_RD_RELEASED: assert property (!rd_n |-> muxed_addr_data_pins_oe[7:0] == 8'h00)
      else $error("read data lanes driven");
   AST_FLAG_IDLE: assert property (flag_mode |-> rd_n && wr_n && !ale && !pp_busy)
      else $error("strobes active in flag mode");
   AST_RELEASE: assert property ($fell(pp_busy) && !flag_mode |-> muxed_addr_data_pins_oe == 16'h0000)
      else $error("pins held after access");
   AST_BOOT_HOLD: assert property (age_q == 3'h7 |-> $stable(boot_mode))
      else $error("boot mode changed");
   AST_RDATA_PULSE: assert property (reg_rdata != 32'h0 |-> $past(reg_rd))
      else $error("read data outside read cycle");
endmodule

bind ad_pin_mux_parallel_port ad_pin_mux_checker u_chk
(
   .clk_sys                 (clk_sys),
   .rst_b                   (rst_b),
   .reg_rd                  (reg_rd),
   .reg_rdata               (reg_rdata),
   .muxed_addr_data_pins_oe (muxed_addr_data_pins_oe),
   .ale                     (ale),
   .rd_n                    (rd_n),
   .wr_n                    (wr_n),
   .boot_mode               (boot_mode),
   .flag_mode               (flag_mode),
   .pp_busy                 (pp_busy)
);

/* File: verif/ext_latch_mem.sv */
`timescale 1ns/1ns
module ext_latch_mem
(
   input wire logic        clk_sys,
   input wire logic [15:0] pins,
   input wire logic        ale,
   input wire logic        rd_n,
   input wire logic        wr_n,
   output logic [15:0]     drive
);
   logic [15:0] mem_q [256];
   logic [7:0]  idx_q;
   // low byte of the latched address picks the word; enough for a few locations
   always_ff @(posedge clk_sys)
   begin
      if (ale)
         idx_q <= pins[7:0];
      if (!wr_n)
         mem_q[idx_q] <= pins;
   end
   // released lines float up to the pull-up level, never the last value
   assign drive = rd_n ? 16'hffff : mem_q[idx_q];
endmodule

/* File: verif/tb.sv */
`timescale 1ns/1ns
`include "ad_pin_mux_defs.svh"
module tb;
   import ad_pin_mux_pkg::*;
   logic        clk_sys;
   logic        rst_b;
   logic [7:0]  reg_addr;
   logic [31:0] reg_wdata;
   logic        reg_wr;
   logic        reg_rd;
   logic [31:0] reg_rdata;
   logic [15:0] pins_out;
   logic [15:0] pins_oe;
   logic [15:0] pins_in;
   logic [15:0] ext_drive;
   logic        ale;
   logic        rd_n;
   logic        wr_n;
   logic [1:0]  straps;
   boot_mode_t  boot_mode;
   logic        flag_mode;
   logic        pp_busy;
   int          fails;
   int          num_checks;
   int          cyc;
   assign pins_in = (pins_out & pins_oe) | (ext_drive & ~pins_oe);
   ad_pin_mux_parallel_port uut
   (
      .clk_sys(clk_sys), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .muxed_addr_data_pins_in(pins_in), .muxed_addr_data_pins_out(pins_out),
      .muxed_addr_data_pins_oe(pins_oe), .ale(ale), .rd_n(rd_n), .wr_n(wr_n),
      .boot_select_straps(straps), .boot_mode(boot_mode), .flag_mode(flag_mode),
      .pp_busy(pp_busy)
   );
   ext_latch_mem u_mem
   (
      .clk_sys(clk_sys), .pins(pins_in), .ale(ale), .rd_n(rd_n), .wr_n(wr_n),
      .drive(ext_drive)
   );
   task automatic tally_and_finish;
      if (fails == 0 && num_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         fails++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge clk_sys);
      reg_wr    <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      @(posedge clk_sys);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge clk_sys);
      reg_rd   <= 1'b0;
      #1;
      chk(reg_rdata, exp);
   endtask
   // one access; checks pins in the address phase and {oe, driven data} in the strobe
   task automatic pp(input logic [23:0] a, input logic [15:0] d, input logic w,
                     input logic [15:0] ea, input logic [31:0] ed);
      int n;
      wr(`REG_PP_ADDR, {8'h00, a});
      wr(`REG_PP_DATA, {16'h0000, d});
      wr(`REG_PP_CTRL, {30'h0, w, 1'b1});
      n = 0;
      while (!ale && n < 8)
      begin
         @(negedge clk_sys);
         n++;
      end
      chk({16'h0000, pins_out}, {16'h0000, ea});
      while (rd_n && wr_n && n < 16)
      begin
         @(negedge clk_sys);
         n++;
      end
      chk({pins_oe, pins_out & pins_oe}, ed);
      while (pp_busy && n < 24)
      begin
         @(negedge clk_sys);
         n++;
      end
      chk({31'h0, pp_busy}, 32'h0);
   endtask
   initial
   begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         fails++;
         tally_and_finish;
      end
   end
   initial
   begin
      rst_b = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 32'h0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      straps = 2'h0;
      fails = 0;
      num_checks = 0;
      cyc = 0;
      for (int i = 0; i < 4; i++)
      begin
         @(posedge clk_sys);
         rst_b  <= 1'b0;
         straps <= 2'(i);
         repeat (12) @(posedge clk_sys);
         rst_b <= 1'b1;
         #1;
         chk({28'h0, pins_oe == 16'h0, rd_n, wr_n, ale}, 32'he);
         repeat (6) @(posedge clk_sys);
         rd(`REG_BOOT, {29'h0, 1'b1, 2'(i)});
         chk({30'h0, boot_mode}, 32'(i));
      end
      rd(`REG_SYSTEM_CONTROL_REG, 32'h0);
      wr(`REG_SYSTEM_CONTROL_REG, 32'hffff_ffff);
      rd(`REG_SYSTEM_CONTROL_REG, 32'h0010_0003);
      chk({31'h0, flag_mode}, 32'h0);
      wr(`REG_SYSTEM_CONTROL_REG, 32'h3);
      pp(24'h001234, 16'hbeef, 1'b1, 16'h1234, 32'hffff_beef);
      pp(24'h001234, 16'h0000, 1'b0, 16'h1234, 32'h0);
      rd(`REG_PP_DATA, 32'hbeef);
      wr(`REG_SYSTEM_CONTROL_REG, 32'h1);
      pp(24'habcd56, 16'h005a, 1'b1, 16'habcd, 32'hffff_565a);
      pp(24'habcd56, 16'h0000, 1'b0, 16'habcd, 32'hff00_5600);
      rd(`REG_PP_DATA, 32'h5a);
      wr(`REG_PP_CTRL, 32'h1);
      wr(`REG_SYSTEM_CONTROL_REG, 32'h0);
      @(negedge clk_sys);
      chk({30'h0, pp_busy, ale}, 32'h0);
      wr(`REG_SYSTEM_CONTROL_REG, 32'h0010_0000);
      wr(`REG_FLAG_DIR, 32'h00ff);
      wr(`REG_FLAG_OUT, 32'h0012);
      @(negedge clk_sys);
      chk({31'h0, flag_mode}, 32'h1);
      chk({pins_oe, pins_out}, 32'hff00_1200);
      repeat (4) @(posedge clk_sys);
      rd(`REG_FLAG_IN, 32'hff12);
      wr(`REG_PP_CTRL, 32'h1);
      @(negedge clk_sys);
      chk({30'h0, pp_busy, ale}, 32'h0);
      wr(`REG_SYSTEM_CONTROL_REG, 32'h0010_0001);
      @(negedge clk_sys);
      chk({31'h0, flag_mode}, 32'h0);
      tally_and_finish;
   end
endmodule
